/* File: core/rpic_consts.svh */
// offsets, field positions, reset values and timing counts of the system control block
`ifndef RPIC_CONSTS_SVH
`define RPIC_CONSTS_SVH
`define RPIC_POWER_CONTROL_OFF 8'h87
`define RPIC_CHP_OFF 8'hbf
`define RPIC_FPCMD_OFF 8'he8
`define RPIC_FPADDR_OFF 8'he9
`define RPIC_SEC_OFF 8'hea
`define RPIC_POWER_CONTROL_RST 8'h30
`define RPIC_POWER_CONTROL_KEEP 8'h10
`define RPIC_PD_BIT 1
`define RPIC_CHP_RST 8'h00
`define RPIC_CHP_WMASK 8'h91
`define RPIC_SWRST_BIT 7
`define RPIC_AUX_BIT 4
`define RPIC_PROGEN_BIT 0
`define RPIC_CMD_RST 8'h00
`define RPIC_CMD_WMASK 8'h87
`define RPIC_CMD_FIXED 8'h10
`define RPIC_CMD_EN_BIT 7
`define RPIC_CMD_ERASE_BIT 2
`define RPIC_CMD_WRITE_BIT 1
`define RPIC_CMD_READ_BIT 0
`define RPIC_FPADDR_RST 8'h00
`define RPIC_ERASE_ALL_ADDR 8'hff
`define RPIC_SEC_ERASED 8'hff
`define RPIC_LOCK_BIT 0
`define RPIC_PORT_PRESET 8'hff
`define RPIC_SP_PRESET 8'h07
`define RPIC_LOADER_BASE 16'hf000
`define RPIC_UNIT_SHIFT 9
`define RPIC_MC_CLKS 12
`define RPIC_STATE5_PHASE2_IDX 9
`define RPIC_RST_SAMPLES 2
`define RPIC_CLK_MHZ 125
`define RPIC_POR_HOLD_MS 240
`define RPIC_POR_HOLD_CYCLES (`RPIC_POR_HOLD_MS * `RPIC_CLK_MHZ * 1000)
`define RPIC_OSC_SETTLE_US 10
`define RPIC_OSC_SETTLE_CYCLES (`RPIC_OSC_SETTLE_US * `RPIC_CLK_MHZ)
`define RPIC_SWRST_CYCLES (2 * `RPIC_MC_CLKS)
`endif

/* File: core/rpic_pkg.sv */
// types of the system control block
package rpic_pkg;
   typedef enum logic [1:0] {
      RPIC_RUN,
      RPIC_PWRDN,
      RPIC_SETTLE
   } rpic_pwr_t;
endpackage

/* File: core/rpic_top.sv */
// reset, power-down and in-system programming control
// How it works
// - power-down bit stops all clocks, oscillator too
// - wake by reset or enabled edge interrupt
// - reset pin sampled once per machine cycle
// - short reset glitches are filtered out
// - reset presets port latches and stack pointer
// - reset clears registers except power and security, power-on and soft reset load power 30h, pin reset keeps power bit 4
// - power-on reset held 240 ms after supply
// - boot byte code sets loader start address
// - soft reset bit with program enable resets
// - aux ram enable bit gates aux ram
// - program enable bit allows flash programming
// - command bits enable, erase, write, read
// - hardware programming entry from pins at reset
// - jump into loader enters programming mode
// - security bits only rise by erase-all
// - lock bit zero denies flash and settings except erase-all
// - edge select bit picks falling-edge trigger
`include "rpic_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module rpic_top #(
   parameter int unsigned POR_HOLD_CYCLES = `RPIC_POR_HOLD_CYCLES,
   parameter int unsigned OSC_SETTLE_CYCLES = `RPIC_OSC_SETTLE_CYCLES,
   parameter int unsigned NUM_IRQ = 4
) (
   input wire logic core_clk, // oscillator clock
   input wire logic rst_b, // synchronous logic reset, active low
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [7:0] reg_rdata, // read data, cycle after strobe
   input wire logic ext_rst_pin, // external reset pin, active high
   input wire logic supply_ok, // supply above threshold
   input wire logic [NUM_IRQ-1:0] ext_irq_b, // external interrupt pins
   input wire logic [NUM_IRQ-1:0] irq_enable, // interrupt enables
   input wire logic [NUM_IRQ-1:0] irq_edge_select, // 1 falling edge, 0 low level
   input wire logic port2_bit7, // mode pin
   input wire logic port2_bit6, // mode pin
   input wire logic port4_bit3, // mode pin
   input wire logic [7:0] boot_cfg_byte, // flash byte at top address
   input wire logic fetch_valid, // core fetch strobe
   input wire logic [15:0] fetch_addr, // core fetch address
   output logic sys_reset, // full reset to core and peripherals
   output logic [7:0] port_latch_preset, // port latch value under reset
   output logic [7:0] stack_ptr_preset, // stack pointer value under reset
   output logic osc_enable, // oscillator run
   output logic clk_run, // core and peripheral clocks run
   output logic [NUM_IRQ-1:0] irq_level_pending, // level-mode interrupt requests
   output logic aux_ram_enable, // aux ram access granted
   output logic isp_mode, // in-system programming mode
   output logic [15:0] loader_base, // loader region start
   output logic flash_erase_req, // one-cycle erase request
   output logic flash_write_req, // one-cycle write request
   output logic flash_read_req, // one-cycle read request
   output logic [7:0] flash_cmd_addr, // address with request
   output logic code_locked // lock bit programmed
);
   initial begin
      if (NUM_IRQ < 1 || NUM_IRQ > 8 || POR_HOLD_CYCLES < 2 || POR_HOLD_CYCLES >= (1 << 25)
          || OSC_SETTLE_CYCLES < 1 || OSC_SETTLE_CYCLES >= (1 << 16)) begin
         $error("rpic_top: parameter out of range");
      end
   end

   // ********************
   // reset sources
   // ********************
   logic [3:0] mc_cnt_reg;
   logic state5_phase2;
   logic pin_q1_reg;
   logic pin_q2_reg;
   logic [1:0] pin_cnt_reg;
   logic ext_rst_active;
   logic [24:0] por_cnt_reg;
   logic por_active_reg;
   logic [4:0] swrst_cnt_reg;
   logic swrst_active;
   logic swrst_fire;
   logic [7:0] power_control_reg;
   logic [7:0] chp_reg;
   logic [7:0] cmd_reg;
   logic [7:0] fpaddr_reg;
   logic [7:0] sec_reg;
   rpic_pkg::rpic_pwr_t pwr_reg;
   logic [15:0] settle_cnt_reg;
   logic wake_irq;
   logic hw_isp_reg;
   logic loader_active_reg;

   assign state5_phase2 = (mc_cnt_reg == 4'(`RPIC_STATE5_PHASE2_IDX));

   always_ff @(posedge core_clk) begin
      if (!rst_b || !clk_run || mc_cnt_reg == 4'(`RPIC_MC_CLKS - 1)) begin
         mc_cnt_reg <= 4'h0;
      end else begin
         mc_cnt_reg <= mc_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pin_q1_reg <= 1'b0;
         pin_q2_reg <= 1'b0;
      end else begin
         pin_q1_reg <= ext_rst_pin;
         pin_q2_reg <= pin_q1_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pin_cnt_reg <= 2'h0;
      end else if (state5_phase2 && clk_run) begin
         if (!(pin_q1_reg && pin_q2_reg)) begin
            pin_cnt_reg <= 2'h0;
         end else if (pin_cnt_reg != 2'(`RPIC_RST_SAMPLES)) begin
            pin_cnt_reg <= pin_cnt_reg + 2'h1;
         end
      end
   end
   assign ext_rst_active = (pin_cnt_reg == 2'(`RPIC_RST_SAMPLES));

   always_ff @(posedge core_clk) begin
      if (!rst_b || !supply_ok) begin
         por_active_reg <= 1'b1;
         por_cnt_reg <= 25'h0;
      end else if (por_active_reg) begin
         if (por_cnt_reg == 25'(POR_HOLD_CYCLES - 1)) begin
            por_active_reg <= 1'b0;
         end else begin
            por_cnt_reg <= por_cnt_reg + 25'h1;
         end
      end
   end

   assign swrst_fire = chp_reg[`RPIC_SWRST_BIT] && chp_reg[`RPIC_PROGEN_BIT];
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         swrst_cnt_reg <= 5'h0;
      end else if (swrst_fire) begin
         swrst_cnt_reg <= 5'(`RPIC_SWRST_CYCLES);
      end else if (swrst_cnt_reg != 5'h0) begin
         swrst_cnt_reg <= swrst_cnt_reg - 5'h1;
      end
   end
   assign swrst_active = (swrst_cnt_reg != 5'h0);
   assign sys_reset = ext_rst_active || por_active_reg || swrst_active;

   always_ff @(posedge core_clk) begin
      if (!rst_b || sys_reset) begin
         port_latch_preset <= `RPIC_PORT_PRESET;
         stack_ptr_preset <= `RPIC_SP_PRESET;
      end else begin
         port_latch_preset <= 8'h00;
         stack_ptr_preset <= 8'h00;
      end
   end

   // ********************
   // power-down and wake
   // ********************
   // falling edge or low level
   genvar gi;
   logic [NUM_IRQ-1:0] irq_prev_reg;
   logic [NUM_IRQ-1:0] irq_wake;
   generate
      for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
         always_ff @(posedge core_clk) begin
            if (!rst_b) begin
               irq_prev_reg[gi] <= 1'b1;
            end else begin
               irq_prev_reg[gi] <= ext_irq_b[gi];
            end
         end
         assign irq_wake[gi] = irq_enable[gi] && irq_edge_select[gi]
                               && irq_prev_reg[gi] && !ext_irq_b[gi];
         assign irq_level_pending[gi] = irq_enable[gi] && !irq_edge_select[gi]
                                        && !ext_irq_b[gi];
      end
   endgenerate
   assign wake_irq = |irq_wake;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pwr_reg <= rpic_pkg::RPIC_RUN;
         settle_cnt_reg <= 16'h0;
      end else begin
         unique case (pwr_reg)
            rpic_pkg::RPIC_RUN: begin
               if (power_control_reg[`RPIC_PD_BIT] && !sys_reset) begin
                  pwr_reg <= rpic_pkg::RPIC_PWRDN;
               end
            end
            rpic_pkg::RPIC_PWRDN: begin
               settle_cnt_reg <= 16'h0;
               if (ext_rst_pin || wake_irq || !supply_ok) begin
                  pwr_reg <= rpic_pkg::RPIC_SETTLE;
               end
            end
            rpic_pkg::RPIC_SETTLE: begin
               if (settle_cnt_reg == 16'(OSC_SETTLE_CYCLES - 1)) begin
                  pwr_reg <= rpic_pkg::RPIC_RUN;
               end else begin
                  settle_cnt_reg <= settle_cnt_reg + 16'h1;
               end
            end
         endcase
      end
   end
   assign osc_enable = (pwr_reg != rpic_pkg::RPIC_PWRDN);
   assign clk_run = (pwr_reg == rpic_pkg::RPIC_RUN);

   // ********************
   // programming mode
   // ********************
   // pin entry latched under reset
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         hw_isp_reg <= 1'b0;
      end else if (ext_rst_active) begin
         hw_isp_reg <= (!port2_bit7 && !port2_bit6) || !port4_bit3;
      end else if (sys_reset) begin
         hw_isp_reg <= 1'b0;
      end
   end

   assign loader_base = `RPIC_LOADER_BASE
                        + (16'(boot_cfg_byte[7:5]) << `RPIC_UNIT_SHIFT);

   always_ff @(posedge core_clk) begin
      if (!rst_b || sys_reset) begin
         loader_active_reg <= 1'b0;
      end else if (fetch_valid) begin
         loader_active_reg <= (fetch_addr >= loader_base);
      end
   end

   assign isp_mode = hw_isp_reg || loader_active_reg || chp_reg[`RPIC_PROGEN_BIT];
   assign aux_ram_enable = chp_reg[`RPIC_AUX_BIT];
   assign code_locked = !sec_reg[`RPIC_LOCK_BIT];

   // ********************
   // registers
   // ********************
   logic wr_power_control;
   logic wr_chp;
   logic wr_cmd;
   logic wr_addr;
   logic wr_sec;
   logic cmd_any;
   logic erase_all;
   logic cmd_go;
   assign wr_power_control = reg_wr && reg_addr == `RPIC_POWER_CONTROL_OFF;
   assign wr_chp = reg_wr && reg_addr == `RPIC_CHP_OFF;
   assign wr_cmd = reg_wr && reg_addr == `RPIC_FPCMD_OFF;
   assign wr_addr = reg_wr && reg_addr == `RPIC_FPADDR_OFF && !code_locked;
   assign wr_sec = reg_wr && reg_addr == `RPIC_SEC_OFF && !code_locked && isp_mode;
   assign cmd_any = |cmd_reg[2:0];
   assign erase_all = cmd_reg[`RPIC_CMD_ERASE_BIT] && fpaddr_reg == `RPIC_ERASE_ALL_ADDR;
   assign cmd_go = cmd_reg[`RPIC_CMD_EN_BIT] && cmd_any && isp_mode
                   && (!code_locked || erase_all);

   // power control: pin reset keeps bit 4, power-on and soft reset load 30h
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         power_control_reg <= `RPIC_POWER_CONTROL_RST;
      end else if (sys_reset) begin
         if (por_active_reg || swrst_active) begin
            power_control_reg <= `RPIC_POWER_CONTROL_RST;
         end else begin
            power_control_reg <= power_control_reg & `RPIC_POWER_CONTROL_KEEP;
         end
      end else if (wr_power_control) begin
         power_control_reg <= reg_wdata;
      end else if (pwr_reg == rpic_pkg::RPIC_SETTLE) begin
         power_control_reg[`RPIC_PD_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b || sys_reset || swrst_fire) begin
         chp_reg <= `RPIC_CHP_RST;
      end else if (wr_chp) begin
         chp_reg <= reg_wdata & `RPIC_CHP_WMASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b || sys_reset) begin
         fpaddr_reg <= `RPIC_FPADDR_RST;
      end else if (wr_addr) begin
         fpaddr_reg <= reg_wdata;
      end
   end

   // action bits clear after issue, write wins
   always_ff @(posedge core_clk) begin
      if (!rst_b || sys_reset) begin
         cmd_reg <= `RPIC_CMD_RST;
      end else if (wr_cmd) begin
         cmd_reg <= reg_wdata & `RPIC_CMD_WMASK;
      end else if (cmd_any) begin
         cmd_reg[2:0] <= 3'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b || sys_reset) begin
         flash_erase_req <= 1'b0;
         flash_write_req <= 1'b0;
         flash_read_req <= 1'b0;
         flash_cmd_addr <= 8'h00;
      end else begin
         flash_erase_req <= cmd_go && cmd_reg[`RPIC_CMD_ERASE_BIT];
         flash_write_req <= cmd_go && !cmd_reg[`RPIC_CMD_ERASE_BIT]
                            && cmd_reg[`RPIC_CMD_WRITE_BIT];
         flash_read_req <= cmd_go && !cmd_reg[`RPIC_CMD_ERASE_BIT]
                           && !cmd_reg[`RPIC_CMD_WRITE_BIT] && cmd_reg[`RPIC_CMD_READ_BIT];
         if (cmd_go) begin
            flash_cmd_addr <= fpaddr_reg;
         end
      end
   end

   // bits only fall by write, rise by erase-all
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         sec_reg <= `RPIC_SEC_ERASED;
      end else if (cmd_go && erase_all) begin
         sec_reg <= `RPIC_SEC_ERASED;
      end else if (wr_sec) begin
         sec_reg <= sec_reg & reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `RPIC_POWER_CONTROL_OFF: reg_rdata <= power_control_reg;
            `RPIC_CHP_OFF: reg_rdata <= chp_reg;
            `RPIC_FPCMD_OFF: reg_rdata <= cmd_reg | `RPIC_CMD_FIXED;
            `RPIC_FPADDR_OFF: reg_rdata <= code_locked ? 8'h00 : fpaddr_reg;
            `RPIC_SEC_OFF: reg_rdata <= code_locked ? 8'h00 : sec_reg;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ********************
   // checks
   // ********************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   AST_PD_STOPS: assert property (
      pwr_reg == rpic_pkg::RPIC_PWRDN |-> !osc_enable && !clk_run)
      else $error("clocks run in power-down");
   AST_PD_WAKE: assert property (
      pwr_reg == rpic_pkg::RPIC_PWRDN && (wake_irq || ext_rst_pin)
      |=> pwr_reg == rpic_pkg::RPIC_SETTLE)
      else $error("power-down did not wake");
   AST_SAMPLE_STATE5_PHASE2: assert property (
      pin_cnt_reg != $past(pin_cnt_reg) |-> $past(state5_phase2))
      else $error("reset pin sampled off state5_phase2");
   AST_GLITCH: assert property (
      $rose(pin_q1_reg) ##1 !pin_q1_reg |-> !ext_rst_active [*2])
      else $error("glitch caused reset");
   AST_PRESET: assert property (
      sys_reset |=> port_latch_preset == 8'hff && stack_ptr_preset == 8'h07)
      else $error("reset presets wrong");
   AST_POWER_CONTROL_KEEP: assert property (
      ext_rst_active && !por_active_reg && !swrst_active
      |=> power_control_reg == ($past(power_control_reg) & 8'h10))
      else $error("power control reset value wrong");
   AST_POR_LOW: assert property (
      !supply_ok |=> sys_reset ##1 sys_reset)
      else $error("power-on reset not held");
   AST_SWRST: assert property (
      swrst_fire |=> sys_reset && !chp_reg[7] [*8])
      else $error("software reset missing");
   AST_AUX_RST: assert property (
      sys_reset |=> !aux_ram_enable)
      else $error("aux ram left open by reset");
   AST_NO_PROG: assert property (
      flash_write_req || flash_read_req |-> $past(isp_mode) && $past(!code_locked))
      else $error("flash access without programming mode");
   AST_HW_ISP: assert property (
      ext_rst_active && !port4_bit3 |=> isp_mode)
      else $error("pin entry to programming missed");
   AST_SEC_RISE: assert property (
      (sec_reg & ~$past(sec_reg)) != 8'h00 |-> $past(cmd_go && erase_all))
      else $error("security bit rose without erase-all");
   AST_SETTLE: assert property (
      $rose(clk_run) |-> $past(pwr_reg) == rpic_pkg::RPIC_SETTLE
      && $past(settle_cnt_reg) == 16'(OSC_SETTLE_CYCLES - 1))
      else $error("clocks resumed before settling");

   COV_PD_IRQ: cover property (
      pwr_reg == rpic_pkg::RPIC_PWRDN ##1 pwr_reg == rpic_pkg::RPIC_SETTLE);
   COV_EXT_RST: cover property ($rose(ext_rst_active));
   COV_SWRST: cover property (swrst_fire);
   COV_ERASE_ALL: cover property (cmd_go && erase_all);
endmodule
`default_nettype wire

/* File: verification/rpic_far_model.sv */
// far-side model: reset source, mode pins and flash request counter
`timescale 1ns/1ps
`default_nettype none
module rpic_far_model (
   input wire logic core_clk, // clock
   input wire logic rst_go, // start a reset pulse
   input wire logic [7:0] rst_len, // pulse length in clocks
   input wire logic [1:0] isp_sel, // 1 pulls port2 pair low, 2 pulls port4_bit3 low
   input wire logic erase_req, // erase request
   input wire logic write_req, // write request
   input wire logic read_req, // read request
   input wire logic [7:0] cmd_addr, // address beside request
   output logic ext_rst_pin, // reset pin
   output logic port2_bit7, // mode pin
   output logic port2_bit6, // mode pin
   output logic port4_bit3, // mode pin
   output logic [7:0] n_erase, // erase count
   output logic [7:0] n_write, // write count
   output logic [7:0] n_read, // read count
   output logic [7:0] last_addr // address of last request
);
   logic [7:0] left = 8'h00;
   always @(posedge core_clk) begin
      if (rst_go) begin
         left <= rst_len;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   assign ext_rst_pin = (left != 8'h00);
   assign port2_bit7 = ~isp_sel[0];
   assign port2_bit6 = ~isp_sel[0];
   assign port4_bit3 = ~isp_sel[1];
   // flash side request tally
   initial begin
      n_erase = 8'h00;
      n_write = 8'h00;
      n_read = 8'h00;
      last_addr = 8'h00;
   end
   always @(posedge core_clk) begin
      if (erase_req) n_erase <= n_erase + 8'h01;
      if (write_req) n_write <= n_write + 8'h01;
      if (read_req) n_read <= n_read + 8'h01;
      if (erase_req | write_req | read_req) last_addr <= cmd_addr;
   end
endmodule
`default_nettype wire

/* File: verification/rpic_top_test.sv */
// self-checking bench of the system control block
`timescale 1ns/1ps
`default_nettype none
module rpic_top_test;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic ext_rst_pin, supply_ok = 1'b1, port2_bit7, port2_bit6, port4_bit3;
   logic [3:0] ext_irq_b = 4'hf, irq_enable = 4'h0, irq_edge_select = 4'h0, irq_pend;
   logic [7:0] boot_cfg_byte = 8'h00, port_pre, sp_pre, cmd_addr, n_er, n_wr, n_rd, l_addr;
   logic fetch_valid = 1'b0;
   logic [15:0] fetch_addr = 16'h0000, loader_base;
   logic sys_reset, osc_enable, clk_run, aux_ram_enable, isp_mode, code_locked;
   logic er_req, wr_req, rd_req, rst_go = 1'b0;
   logic [7:0] rst_len = 8'h00;
   logic [1:0] isp_sel = 2'h0;
   int err_count = 0, comparisons = 0, waited, k;
   always #4 core_clk = ~core_clk;
   rpic_top #(.POR_HOLD_CYCLES(20), .OSC_SETTLE_CYCLES(4)) u_dut (.core_clk(core_clk),
      .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_rst_pin(ext_rst_pin),
      .supply_ok(supply_ok), .ext_irq_b(ext_irq_b), .irq_enable(irq_enable),
      .irq_edge_select(irq_edge_select), .port2_bit7(port2_bit7), .port2_bit6(port2_bit6),
      .port4_bit3(port4_bit3), .boot_cfg_byte(boot_cfg_byte), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .sys_reset(sys_reset), .port_latch_preset(port_pre),
      .stack_ptr_preset(sp_pre), .osc_enable(osc_enable), .clk_run(clk_run),
      .irq_level_pending(irq_pend), .aux_ram_enable(aux_ram_enable), .isp_mode(isp_mode),
      .loader_base(loader_base), .flash_erase_req(er_req), .flash_write_req(wr_req),
      .flash_read_req(rd_req), .flash_cmd_addr(cmd_addr), .code_locked(code_locked));
   rpic_far_model u_far (.core_clk(core_clk), .rst_go(rst_go), .rst_len(rst_len),
      .isp_sel(isp_sel), .erase_req(er_req), .write_req(wr_req), .read_req(rd_req),
      .cmd_addr(cmd_addr), .ext_rst_pin(ext_rst_pin), .port2_bit7(port2_bit7),
      .port2_bit6(port2_bit6), .port4_bit3(port4_bit3), .n_erase(n_er), .n_write(n_wr),
      .n_read(n_rd), .last_addr(l_addr));
   // ***********
   // bus tasks
   // ***********
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
   endtask
   function automatic logic pick(input int sel);
      return (sel == 0) ? sys_reset : (sel == 1) ? osc_enable : clk_run;
   endfunction
   // bounded wait for a design output to reach a level
   task automatic wait_on(input int sel, input logic val, input int n);
      for (waited = 0; waited < n; waited++) begin
         @(posedge core_clk);
         #1;
         if (pick(sel) === val) break;
      end
   endtask
   task automatic fetch(input logic [15:0] a);
      @(posedge core_clk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      @(posedge core_clk);
      fetch_valid <= 1'b0;
      #1;
   endtask
   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      err_count++;
      results();
   end
   // ***********
   // tests
   // ***********
   initial begin
      repeat (6) @(posedge core_clk);
      #1;
      check("port_latch", 16'h00ff, {8'h00, port_pre});
      check("stack_ptr", 16'h0007, {8'h00, sp_pre});
      @(posedge core_clk);
      rst_b <= 1'b1;
      wait_on(0, 1'b0, 60);
      check("por_hold", 16'h0001, {15'h0000, waited >= 18});
      chk_rd(8'h87, 8'h30);
      chk_rd(8'hbf, 8'h00);
      chk_rd(8'he8, 8'h10);
      chk_rd(8'he9, 8'h00);
      chk_rd(8'hea, 8'hff);
      chk_rd(8'h00, 8'h00);
      for (k = 0; k < 8; k++) begin
         @(posedge core_clk);
         boot_cfg_byte <= {k[2:0], 5'h1f};
         @(posedge core_clk);
         #1;
         check("loader_base", 16'hf000 + k * 512, loader_base);
      end
      boot_cfg_byte <= 8'h00;
      fetch(16'hefff);
      check("isp_mode", 16'h0000, {15'h0000, isp_mode});
      fetch(16'hf000);
      check("isp_mode", 16'h0001, {15'h0000, isp_mode});
      fetch(16'h0100);
      wr(8'he9, 8'h12);
      wr(8'he8, 8'h82);
      repeat (4) @(posedge core_clk);
      check("write_cnt", 16'h0000, {8'h00, n_wr});
      wr(8'hbf, 8'h10);
      #1;
      check("aux_ram", 16'h0001, {15'h0000, aux_ram_enable});
      wr(8'hbf, 8'h11);
      #1;
      check("isp_mode", 16'h0001, {15'h0000, isp_mode});
      wr(8'he8, 8'h84);
      wr(8'he8, 8'h82);
      wr(8'he8, 8'h81);
      repeat (4) @(posedge core_clk);
      check("req_cnts", 16'h0111, {4'h0, n_er[3:0], n_wr[3:0], n_rd[3:0]});
      check("req_addr", 16'h0012, {8'h00, l_addr});
      wr(8'he9, 8'hff);
      wr(8'hea, 8'hfe);
      #1;
      check("locked", 16'h0001, {15'h0000, code_locked});
      chk_rd(8'he9, 8'h00);
      wr(8'he8, 8'h82);
      wr(8'hea, 8'hff);
      repeat (4) @(posedge core_clk);
      check("write_cnt", 16'h0001, {8'h00, n_wr});
      check("locked", 16'h0001, {15'h0000, code_locked});
      wr(8'he8, 8'h84);
      repeat (4) @(posedge core_clk);
      #1;
      check("locked", 16'h0000, {15'h0000, code_locked});
      chk_rd(8'hea, 8'hff);
      wr(8'hbf, 8'h81);
      wait_on(0, 1'b1, 3);
      check("sys_reset", 16'h0001, {15'h0000, sys_reset});
      wait_on(0, 1'b0, 60);
      chk_rd(8'hbf, 8'h00);
      chk_rd(8'h87, 8'h30);
      wr(8'h87, 8'h32);
      repeat (3) @(posedge core_clk);
      #1;
      check("osc_clk", 16'h0000, {14'h0000, osc_enable, clk_run});
      @(posedge core_clk);
      irq_enable <= 4'h1;
      ext_irq_b <= 4'he;
      repeat (10) @(posedge core_clk);
      #1;
      check("level_pend", 16'h0001, {12'h000, irq_pend});
      check("osc_enable", 16'h0000, {15'h0000, osc_enable});
      @(posedge core_clk);
      ext_irq_b <= 4'hf;
      irq_edge_select <= 4'h1;
      @(posedge core_clk);
      ext_irq_b <= 4'he;
      wait_on(1, 1'b1, 5);
      check("osc_clk", 16'h0002, {14'h0000, osc_enable, clk_run});
      wait_on(2, 1'b1, 20);
      check("clk_run", 16'h0001, {15'h0000, clk_run});
      ext_irq_b <= 4'hf;
      chk_rd(8'h87, 8'h30);
      @(posedge core_clk);
      rst_len <= 8'h05;
      rst_go <= 1'b1;
      @(posedge core_clk);
      rst_go <= 1'b0;
      repeat (40) @(posedge core_clk);
      #1;
      check("sys_reset", 16'h0000, {15'h0000, sys_reset});
      for (k = 1; k < 3; k++) begin
         @(posedge core_clk);
         isp_sel <= k[1:0];
         rst_len <= 8'h28;
         rst_go <= 1'b1;
         @(posedge core_clk);
         rst_go <= 1'b0;
         wait_on(0, 1'b1, 40);
         check("sys_reset", 16'h0001, {15'h0000, sys_reset});
         wait_on(0, 1'b0, 60);
         isp_sel <= 2'h0;
         check("isp_mode", 16'h0001, {15'h0000, isp_mode});
         chk_rd(8'h87, 8'h10);
      end
      @(posedge core_clk);
      supply_ok <= 1'b0;
      @(posedge core_clk);
      supply_ok <= 1'b1;
      wait_on(0, 1'b1, 3);
      check("sys_reset", 16'h0001, {15'h0000, sys_reset});
      wait_on(0, 1'b0, 60);
      check("por_hold", 16'h0001, {15'h0000, waited >= 18});
      chk_rd(8'h87, 8'h30);
      results();
   end
endmodule
`default_nettype wire
